// >>> erbs_pkg.sv
// erbs_pkg: constants for the rx buffer size control and tx good frame statistics block
// assumes an apb slave with 32-bit data and word-aligned registers
//
// Function
// - a seven-bit receive buffer length field sits at bits 10 to 4 of the control register, in 16-byte units.
// - the field maps linearly, code times sixteen gives the buffer length, up to 2032 bytes.
// - the buffer length setting steers reception only and never transmit behaviour.
// - a sixteen-bit counter in bits 15 to 0 counts good transmitted frames, bits 31 to 16 read zero.
// - a read clears the counter unless byte enables for bytes 0 and 1 are both low.
package erbs_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ERBS_CTRL_OFF = 8'h00;
  localparam logic [7:0] ERBS_STAT_OFF = 8'h10;
  localparam logic [3:0] ERBS_ALIAS_CLR = 4'h4;
  localparam logic [3:0] ERBS_ALIAS_SET = 4'h8;
  localparam logic [3:0] ERBS_ALIAS_INV = 4'hc;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int ERBS_BSZ_LSB = 4;
  localparam int ERBS_BSZ_W = 7;
  localparam int ERBS_UNIT_SHIFT = 4;
  localparam logic [6:0] ERBS_BSZ_RST = 7'h00;
  localparam logic [15:0] ERBS_CNT_RST = 16'h0000;
  localparam logic [15:0] ERBS_CNT_MAX = 16'hffff;
endpackage

// >>> erbs_txcnt.sv
// erbs_txcnt: self-clearing good tx frame counter
// assumes tx_ok is a one-cycle pulse per frame
`timescale 1ns/1ns
module erbs_txcnt
  import erbs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_ok,
  input wire logic rd_clr,
  input wire logic wr_en,
  input wire logic [15:0] wr_val,
  output logic [15:0] count
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_en) begin
      cnt_nxt = wr_val;
    end else if (rd_clr) begin
      // a frame landing in the clearing read cycle still counts
      cnt_nxt = tx_ok ? 16'h0001 : ERBS_CNT_RST;
    end else if (tx_ok && cnt_r != ERBS_CNT_MAX) begin
      // saturate rather than wrap, a wrapped count would mislead
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= ERBS_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;

  a_cnt_incr: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_ok && !rd_clr && !wr_en && cnt_r != ERBS_CNT_MAX) |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not step on good frame");
  a_cnt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_ok && !rd_clr && !wr_en) |=> $stable(cnt_r))
    else $error("counter moved without cause");
endmodule // erbs_txcnt

// >>> erbs_top.sv
// erbs_top: apb slave holding rx buffer length control and tx good frame count
// assumes apb3 master on pclk; tx_ok from the transmit engine
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
module erbs_top
  import erbs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic receive_enable_bit,
  input wire logic tx_ok,
  output logic [6:0] rx_descriptor_buffer_length,
  output logic [11:0] rx_buffer_bytes
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic access;
  logic [7:0] base;
  logic [3:0] alias_sel;
  logic hit_ctrl;
  logic hit_stat;
  logic [6:0] bsz_r;
  logic [6:0] bsz_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic err_r;
  logic err_nxt;
  logic [15:0] count;
  logic cnt_wr;
  logic [15:0] cnt_wval;
  logic rd_clr;
  wire [15:0] wmask;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_ctrl;
  logic rd_stat;

  assign access = psel && !penable;
  assign base = {paddr[7:4], 4'h0};
  assign alias_sel = paddr[3:0];
  assign hit_ctrl = base == ERBS_CTRL_OFF;
  assign hit_stat = base == ERBS_STAT_OFF;
  assign wr_ctrl = access && pwrite && hit_ctrl && alias_sel[1:0] == 2'b00;
  assign wr_stat = access && pwrite && hit_stat && alias_sel[1:0] == 2'b00;
  assign rd_ctrl = access && !pwrite && hit_ctrl && alias_sel == 4'h0;
  assign rd_stat = access && !pwrite && hit_stat && alias_sel == 4'h0;

  // one mask lane per low byte enable; the upper lanes carry no bits
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    assign wmask[8*lane +: 8] = {8{pstrb[lane]}};
  end

  // alias write: plain, clear, set or invert
  function automatic logic [15:0] apply_alias(input logic [15:0] cur, input logic [15:0] d,
                                              input logic [15:0] m, input logic [3:0] a);
    logic [15:0] v;
    v = cur;
    case (a)
      ERBS_ALIAS_CLR: v = cur & ~(d & m);
      ERBS_ALIAS_SET: v = cur | (d & m);
      ERBS_ALIAS_INV: v = cur ^ (d & m);
      default: v = (cur & ~m) | (d & m);
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // register access, answered in setup so access phase ends at once
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] ctl_new;
    ctl_new = 16'h0000;
    bsz_nxt = bsz_r;
    prdata_nxt = prdata_r;
    err_nxt = err_r;
    cnt_wr = 1'b0;
    cnt_wval = count;
    rd_clr = 1'b0;
    if (access) begin
      err_nxt = !(hit_ctrl || hit_stat) || alias_sel[1:0] != 2'b00;
      prdata_nxt = 32'h0000_0000;
      if (wr_ctrl) begin
        ctl_new = apply_alias({5'h00, bsz_r, 4'h0}, pwdata[15:0], wmask, alias_sel);
        if (!receive_enable_bit) begin
          bsz_nxt = ctl_new[ERBS_BSZ_LSB +: ERBS_BSZ_W];
        end
      end
      if (wr_stat) begin
        cnt_wr = 1'b1;
        cnt_wval = apply_alias(count, pwdata[15:0], wmask, alias_sel);
      end
      if (rd_ctrl) begin
        prdata_nxt = {21'h00_0000, bsz_r, 4'h0};
      end
      if (rd_stat) begin
        prdata_nxt = {16'h0000, count};
        // clear on read unless low bytes masked
        rd_clr = pstrb[0] || pstrb[1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsz_r <= ERBS_BSZ_RST;
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      bsz_r <= bsz_nxt;
      prdata_r <= prdata_nxt;
      err_r <= err_nxt;
    end
  end

  erbs_txcnt u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .tx_ok(tx_ok),
    .rd_clr(rd_clr),
    .wr_en(cnt_wr),
    .wr_val(cnt_wval),
    .count(count)
  );

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_r;
  // only the receive side sees the length
  assign rx_descriptor_buffer_length = bsz_r;
  assign rx_buffer_bytes = {1'b0, bsz_r, 4'h0};

  // ----------------------------------------------------------------
  // checks: control field
  // ----------------------------------------------------------------
  // locked while receiving
  a_bsz_locked: assert property (@(posedge pclk) disable iff (!presetn)
    receive_enable_bit |=> $stable(bsz_r))
    else $error("buffer length changed while receiving");
  a_bsz_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && alias_sel == 4'h0 && pstrb == 4'hf && !receive_enable_bit)
    |=> bsz_r == $past(pwdata[10:4]))
    else $error("buffer length write lost");
  a_bsz_low_lane: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && alias_sel == 4'h0 && pstrb[1:0] == 2'b01 && !receive_enable_bit)
    |=> bsz_r == {$past(bsz_r[6:4]), $past(pwdata[7:4])})
    else $error("buffer length lane mask ignored");
  a_bsz_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && alias_sel == ERBS_ALIAS_CLR && pstrb[1:0] == 2'b11 && !receive_enable_bit)
    |=> bsz_r == ($past(bsz_r) & ~$past(pwdata[10:4])))
    else $error("buffer length clear alias wrong");
  a_ctrl_readback: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ctrl |=> prdata == {21'h00_0000, $past(bsz_r), 4'h0})
    else $error("control read wrong");
  a_bytes_linear: assert property (@(posedge pclk) disable iff (!presetn)
    rx_buffer_bytes == 12'(bsz_r) * 12'h010)
    else $error("byte length not linear");

  // ----------------------------------------------------------------
  // checks: frame counter
  // ----------------------------------------------------------------
  // read clears
  a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_stat && pstrb[0] && !tx_ok) |=> count == 16'h0000)
    else $error("counter not cleared by read");
  a_read_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_stat && pstrb[1:0] == 2'b00 && !tx_ok) |=> $stable(count))
    else $error("counter cleared by masked read");
  a_read_clear_tx: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_clr && tx_ok) |=> count == 16'h0001)
    else $error("frame lost in clearing read");
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_stat) |=> prdata[31:16] == 16'h0000
      && prdata[15:0] == ($past(alias_sel) == 4'h0 ? $past(count) : 16'h0000))
    else $error("statistics read wrong");
  a_cnt_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stat && alias_sel == ERBS_ALIAS_SET && pstrb[1:0] == 2'b11)
    |=> count == ($past(count) | $past(pwdata[15:0])))
    else $error("counter set alias wrong");
  a_cnt_invert: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stat && alias_sel == ERBS_ALIAS_INV && pstrb[1:0] == 2'b11)
    |=> count == ($past(count) ^ $past(pwdata[15:0])))
    else $error("counter invert alias wrong");

  // ----------------------------------------------------------------
  // checks: bus answer
  // ----------------------------------------------------------------
  // aliases read zero
  a_alias_rd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && alias_sel != 4'h0) |=> prdata == 32'h0000_0000)
    else $error("alias read not zero");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !(hit_ctrl || hit_stat)) |=> err_r && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (access && (hit_ctrl || hit_stat) && alias_sel[1:0] == 2'b00) |=> !err_r)
    else $error("mapped access flagged");
  a_prdata_stands: assert property (@(posedge pclk) disable iff (!presetn)
    !access |=> $stable(prdata))
    else $error("read data moved outside setup");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_rd_clear: cover property (@(posedge pclk) disable iff (!presetn) rd_clr && count != 16'h0000);
  c_rd_clear_tx: cover property (@(posedge pclk) disable iff (!presetn) rd_clr && tx_ok);
  c_locked_wr: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && hit_ctrl && receive_enable_bit);
  c_cnt_invert: cover property (@(posedge pclk) disable iff (!presetn)
    wr_stat && alias_sel == ERBS_ALIAS_INV);
  c_max_len: cover property (@(posedge pclk) disable iff (!presetn) bsz_r == 7'h7f);
endmodule // erbs_top

// >>> testbench.sv
// testbench: self-checking bench for erbs_top over apb
// assumes zero-wait apb slave, tx_ok pulses from the bench
`timescale 1ns/1ns
module testbench
  import erbs_pkg::*;
;
  typedef struct packed {logic [6:0] code; logic [11:0] bytes;} erbs_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, receive_enable_bit, tx_ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [6:0] rx_descriptor_buffer_length;
  logic [11:0] rx_buffer_bytes;
  logic er;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  erbs_row_s rows [4] = '{'{7'h01, 12'h010}, '{7'h03, 12'h030}, '{7'h60, 12'h600},
                          '{7'h7f, 12'h7f0}};
  erbs_top i_erbs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_enable_bit(receive_enable_bit),
    .tx_ok(tx_ok), .rx_descriptor_buffer_length(rx_descriptor_buffer_length),
    .rx_buffer_bytes(rx_buffer_bytes));
  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // bound well above the hundred or so cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  task print_verdict();
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until pready is seen high in the access phase
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse_tx(input int n);
    @(posedge pclk);
    tx_ok <= 1'b1;
    repeat (n) @(posedge pclk);
    tx_ok <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, receive_enable_bit, tx_ok} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ERBS_CTRL_OFF, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0000);
    // linear length, unused bits read zero
    foreach (rows[i]) begin
      apb(1'b1, ERBS_CTRL_OFF, 32'hffff_f80f | {21'h0, rows[i].code, 4'h0}, 4'hf);
      apb(1'b0, ERBS_CTRL_OFF, 32'h0000_0000, 4'hf);
      chk(rd, {21'h0, rows[i].code, 4'h0});
      chk({20'h0, rx_buffer_bytes}, {20'h0, rows[i].bytes});
    end
    receive_enable_bit <= 1'b1;
    apb(1'b1, ERBS_CTRL_OFF, 32'h0000_0050, 4'hf);
    chk({25'h0, rx_descriptor_buffer_length}, 32'h0000_007f);
    receive_enable_bit <= 1'b0;
    // count, keep on no byte enables, clear on read
    pulse_tx(3);
    apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'h3);
    chk(rd, 32'h0000_0003);
    apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0000);
    apb(1'b1, ERBS_STAT_OFF + {4'h0, ERBS_ALIAS_SET}, 32'hffff_0005, 4'hf);
    apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0005);
    chk({31'h0, er}, 32'h0000_0000);
    chk({31'h0, pready}, 32'h0000_0001);
    apb(1'b1, ERBS_STAT_OFF + {4'h0, ERBS_ALIAS_INV}, 32'h0000_00f0, 4'hf);
    apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_00f0);
    apb(1'b1, ERBS_CTRL_OFF + {4'h0, ERBS_ALIAS_CLR}, 32'h0000_0300, 4'hf);
    apb(1'b0, ERBS_CTRL_OFF, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_04f0);
    apb(1'b1, ERBS_CTRL_OFF, 32'h0000_0010, 4'h1);
    apb(1'b0, ERBS_CTRL_OFF, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0410);
    chk({20'h0, rx_buffer_bytes}, 32'h0000_0410);
    // saturate at the top, then a frame inside the clearing read
    apb(1'b1, ERBS_STAT_OFF + {4'h0, ERBS_ALIAS_SET}, 32'h0000_ffff, 4'hf);
    pulse_tx(1);
    fork
      apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'hf);
      pulse_tx(1);
    join
    chk(rd, 32'h0000_ffff);
    apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000, 4'hf);
    chk({31'h0, er}, 32'h0000_0001);
    // mid-run reset clears field and count
    pulse_tx(2);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ERBS_STAT_OFF, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0000);
    chk({25'h0, rx_descriptor_buffer_length}, 32'h0000_0000);
    print_verdict();
  end
endmodule // testbench
